/* File: rtl/ext_xor_defs.svh */
// Purpose: constants for the enable-write and exclusive-or execute block
// Assumes: big-endian bit numbering of the instruction word, bit 0 is msb
// Notes:   field positions are given as lsb-based indices
`ifndef EXT_XOR_DEFS_SVH
`define EXT_XOR_DEFS_SVH
`define OPC_LO          26
`define OPC_HI          31
`define XOP_LO          1
`define XOP_HI          10
`define SRC_LO          21
`define SRC_HI          25
`define DST_LO          16
`define DST_HI          20
`define SRC2_LO         11
`define SRC2_HI         15
`define IMM_LO          0
`define IMM_HI          15
`define REC_BIT         0
`define EIMM_BIT        15
`define SRC_ENABLE_BIT  15
`define OPC_EXT         6'h1f
`define OPC_XORI        6'h1a
`define OPC_XORIS       6'h1b
`define XOP_WR_REG      10'h083
`define XOP_WR_IMM      10'h0a3
`define XOP_XOR         10'h13c
`define ENABLE_RESET    1'b0
`endif

/* File: rtl/ext_xor_pkg.sv */
// Purpose: types for the enable-write and exclusive-or execute block
// Assumes: nothing beyond the defs header
// Notes:   operation codes for the decoder
package ext_xor_pkg;
    typedef enum logic [2:0] {
        OP_NONE   = 3'h0,
        OP_WR_REG = 3'h1,
        OP_WR_IMM = 3'h3,
        OP_XOR    = 3'h2,
        OP_XORI   = 3'h6,
        OP_XORIS  = 3'h7
    } op_t;
endpackage : ext_xor_pkg

/* File: rtl/ext_xor_exec.sv */
// Purpose: decode and execute enable-write and exclusive-or instructions
// Assumes: register file read ports outside; one instruction per valid cycle
// Notes:   results are registered, one cycle after i_valid
`timescale 1ns/10ps
`include "ext_xor_defs.svh"

// What this block does
// RULE1: extended opcode 131 copies source bit 16 into the interrupt enable
// RULE2: extended opcode 163 loads the interrupt enable from the immediate bit
// RULE3: both enable writes are privileged; user mode raises program exception, enable kept
// RULE4: non-zero reserved bits are ignored, no exception raised
// RULE5: extended opcode 316 writes source xor second source to destination
// RULE6: with record flag set, update condition field zero lt gt eq so
// RULE7: opcode 26 xors source with zero-extended immediate
// RULE8: opcode 27 xors source with immediate shifted to upper half
// RULE9: immediate and unrecorded forms alter only destination, no exception or flags
module ext_xor_exec
    import ext_xor_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_valid,
    input  wire logic [31:0] i_instr,
    input  wire logic        i_user_mode,
    input  wire logic [31:0] i_source_register,
    input  wire logic [31:0] i_second_source_register,
    input  wire logic        i_summary_overflow,
    output logic             o_external_interrupt_enable,
    output logic             o_dest_we,
    output logic [4:0]       o_destination_register,
    output logic [31:0]      o_dest_data,
    output logic             o_flags_we,
    output logic [3:0]       o_condition_field_zero,
    output logic             o_program_exception
);
    op_t         op;
    logic [31:0] next_result;
    logic        privileged;

    // decode; reserved fields not checked
    always_comb begin
        op = OP_NONE;
        if (i_instr[`OPC_HI:`OPC_LO] == `OPC_XORI) begin
            op = OP_XORI; // RULE7
        end else if (i_instr[`OPC_HI:`OPC_LO] == `OPC_XORIS) begin
            op = OP_XORIS; // RULE8
        end else if (i_instr[`OPC_HI:`OPC_LO] == `OPC_EXT) begin
            if (i_instr[`XOP_HI:`XOP_LO] == `XOP_WR_REG) begin
                op = OP_WR_REG; // RULE1 RULE4
            end else if (i_instr[`XOP_HI:`XOP_LO] == `XOP_WR_IMM) begin
                op = OP_WR_IMM; // RULE2 RULE4
            end else if (i_instr[`XOP_HI:`XOP_LO] == `XOP_XOR) begin
                op = OP_XOR; // RULE5
            end
        end
    end

    assign privileged = (op == OP_WR_REG) || (op == OP_WR_IMM);

    // result selection
    always_comb begin
        case (op)
            OP_XORI:  next_result = i_source_register ^ {16'h0000, i_instr[`IMM_HI:`IMM_LO]}; // RULE7
            OP_XORIS: next_result = i_source_register ^ {i_instr[`IMM_HI:`IMM_LO], 16'h0000}; // RULE8
            default:  next_result = i_source_register ^ i_second_source_register; // RULE5
        endcase
    end

    // enable bit, blocked in user mode
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_external_interrupt_enable <= `ENABLE_RESET;
        end else if (i_valid && !i_user_mode) begin // RULE3
            if (op == OP_WR_REG) begin
                o_external_interrupt_enable <= i_source_register[`SRC_ENABLE_BIT]; // RULE1
            end else if (op == OP_WR_IMM) begin
                o_external_interrupt_enable <= i_instr[`EIMM_BIT]; // RULE2
            end
        end
    end

    // program exception pulse
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_program_exception <= 1'b0;
        end else begin
            o_program_exception <= i_valid && i_user_mode && privileged; // RULE3 RULE9
        end
    end

    // destination write
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_dest_we              <= 1'b0;
            o_destination_register <= 5'h00;
            o_dest_data            <= 32'h0000_0000;
        end else begin
            o_dest_we <= i_valid && (op == OP_XOR || op == OP_XORI || op == OP_XORIS); // RULE9
            if (i_valid) begin
                o_destination_register <= i_instr[`DST_HI:`DST_LO];
                o_dest_data            <= next_result;
            end
        end
    end

    // condition field zero: lt gt eq so
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_flags_we             <= 1'b0;
            o_condition_field_zero <= 4'h0;
        end else begin
            o_flags_we <= i_valid && op == OP_XOR && i_instr[`REC_BIT]; // RULE6 RULE9
            if (i_valid && op == OP_XOR && i_instr[`REC_BIT]) begin
                o_condition_field_zero <= {next_result[31], !next_result[31] && next_result != 32'h0,
                                           next_result == 32'h0, i_summary_overflow}; // RULE6
            end
        end
    end

    sequence s_wr_user;
        i_valid && i_user_mode && privileged;
    endsequence

    // supervisor-mode enable writes at the issuing edge
    sequence s_wr_reg_sup;
        i_valid && !i_user_mode && op == OP_WR_REG;
    endsequence
    sequence s_wr_imm_sup;
        i_valid && !i_user_mode && op == OP_WR_IMM;
    endsequence

    // exclusive-or forms, split by kind and record flag
    sequence s_xor_rec;
        i_valid && op == OP_XOR && i_instr[`REC_BIT];
    endsequence
    sequence s_xor_norec;
        i_valid && op == OP_XOR && !i_instr[`REC_BIT];
    endsequence
    sequence s_xor_imm;
        i_valid && (op == OP_XORI || op == OP_XORIS);
    endsequence
    sequence s_xor_any;
        i_valid && (op == OP_XOR || op == OP_XORI || op == OP_XORIS);
    endsequence

    AST_USER_KEEPS_ENABLE: assert property (@(posedge i_clk) disable iff (i_rst) // RULE3
        s_wr_user |=> o_program_exception && $stable(o_external_interrupt_enable))
        else $error("user-mode enable write changed enable");
    AST_WR_REG: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
        i_valid && !i_user_mode && op == OP_WR_REG |=> o_external_interrupt_enable == $past(i_source_register[15]))
        else $error("register enable write wrong");
    AST_WR_IMM: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
        i_valid && !i_user_mode && op == OP_WR_IMM |=> o_external_interrupt_enable == $past(i_instr[15]))
        else $error("immediate enable write wrong");
    AST_XOR: assert property (@(posedge i_clk) disable iff (i_rst) // RULE5
        i_valid && op == OP_XOR |=>
            o_dest_we && o_dest_data == ($past(i_source_register) ^ $past(i_second_source_register)))
        else $error("xor result wrong");
    AST_XORI: assert property (@(posedge i_clk) disable iff (i_rst) // RULE7
        i_valid && op == OP_XORI |=> o_dest_data[31:16] == $past(i_source_register[31:16]))
        else $error("xori touched upper half");
    AST_XORIS: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
        i_valid && op == OP_XORIS |=> o_dest_data[15:0] == $past(i_source_register[15:0]))
        else $error("xoris touched lower half");
    AST_FLAG_EQ: assert property (@(posedge i_clk) disable iff (i_rst) // RULE6
        o_flags_we |-> o_condition_field_zero[1] == (o_dest_data == 32'h0))
        else $error("equal flag wrong");
    AST_NO_FLAGS: assert property (@(posedge i_clk) disable iff (i_rst) // RULE9
        i_valid && (op == OP_XORI || op == OP_XORIS) |=> !o_flags_we && !o_program_exception)
        else $error("immediate xor raised flags");
    AST_RESERVED: assert property (@(posedge i_clk) disable iff (i_rst) // RULE4
        i_valid && !i_user_mode && privileged |=> !o_program_exception)
        else $error("exception on supervisor enable write");

    // supervisor-mode enable writes raise no destination, flag or exception strobe
    AST_WR_REG_ONLY_ENABLE: assert property (@(posedge i_clk) disable iff (i_rst) // RULE1
        s_wr_reg_sup |=> !o_dest_we && !o_flags_we && !o_program_exception)
        else $error("register enable write touched other state");
    AST_WR_IMM_ONLY_ENABLE: assert property (@(posedge i_clk) disable iff (i_rst) // RULE2
        s_wr_imm_sup |=> !o_dest_we && !o_flags_we && !o_program_exception)
        else $error("immediate enable write touched other state");
    AST_ENABLE_ONLY_BY_WR: assert property (@(posedge i_clk) disable iff (i_rst) // RULE3
        $changed(o_external_interrupt_enable) && !$past(i_rst) |-> $past(i_valid && !i_user_mode && privileged))
        else $error("enable changed without a supervisor write");
    AST_EXC_ONLY_USER: assert property (@(posedge i_clk) disable iff (i_rst) // RULE3
        o_program_exception |-> $past(i_valid && i_user_mode && privileged))
        else $error("exception without a user-mode enable write");

    // only exclusive-or forms write the destination; unrecorded ones write nothing more
    AST_DEST_ONLY_XOR: assert property (@(posedge i_clk) disable iff (i_rst) // RULE9
        o_dest_we |-> $past(i_valid && (op == OP_XOR || op == OP_XORI || op == OP_XORIS)))
        else $error("destination written by a non-xor instruction");
    AST_IMM_WRITES: assert property (@(posedge i_clk) disable iff (i_rst) // RULE7 RULE8
        s_xor_imm |=> o_dest_we)
        else $error("immediate xor did not write destination");
    AST_XOR_NOREC: assert property (@(posedge i_clk) disable iff (i_rst) // RULE9
        s_xor_norec |=> o_dest_we && !o_flags_we && !o_program_exception)
        else $error("unrecorded xor raised flags");
    AST_DEST_REG: assert property (@(posedge i_clk) disable iff (i_rst) // RULE5
        s_xor_any |=> o_destination_register == $past(i_instr[`DST_HI:`DST_LO]))
        else $error("destination register number wrong");
    AST_XORI_FULL: assert property (@(posedge i_clk) disable iff (i_rst) // RULE7
        i_valid && op == OP_XORI |=>
            o_dest_data == ($past(i_source_register) ^ {16'h0000, $past(i_instr[`IMM_HI:`IMM_LO])}))
        else $error("xori result wrong");
    AST_XORIS_FULL: assert property (@(posedge i_clk) disable iff (i_rst) // RULE8
        i_valid && op == OP_XORIS |=>
            o_dest_data == ($past(i_source_register) ^ {$past(i_instr[`IMM_HI:`IMM_LO]), 16'h0000}))
        else $error("xoris result wrong");

    // recorded xor: flag write strobe and each flag
    AST_FLAGS_ONLY_REC: assert property (@(posedge i_clk) disable iff (i_rst) // RULE6
        o_flags_we |-> $past(i_valid && op == OP_XOR && i_instr[`REC_BIT]))
        else $error("flags written by an unrecorded instruction");
    AST_XOR_REC_WE: assert property (@(posedge i_clk) disable iff (i_rst) // RULE6
        s_xor_rec |=> o_dest_we && o_flags_we)
        else $error("recorded xor did not write flags");
    AST_FLAG_LT: assert property (@(posedge i_clk) disable iff (i_rst) // RULE6
        o_flags_we |-> o_condition_field_zero[3] == o_dest_data[31])
        else $error("less-than flag wrong");
    AST_FLAG_GT: assert property (@(posedge i_clk) disable iff (i_rst) // RULE6
        o_flags_we |-> o_condition_field_zero[2] == (!o_dest_data[31] && o_dest_data != 32'h0))
        else $error("greater-than flag wrong");
    AST_FLAG_ONEHOT: assert property (@(posedge i_clk) disable iff (i_rst) // RULE6
        o_flags_we |-> $onehot(o_condition_field_zero[3:1]))
        else $error("compare flags not exactly one");
    AST_FLAG_SO: assert property (@(posedge i_clk) disable iff (i_rst) // RULE6
        s_xor_rec |=> o_condition_field_zero[0] == $past(i_summary_overflow))
        else $error("summary overflow flag wrong");

    // outputs hold between updates
    AST_FLAGS_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // RULE9
        !(i_valid && op == OP_XOR && i_instr[`REC_BIT]) |=> $stable(o_condition_field_zero))
        else $error("flags changed without a recorded xor");
    AST_DEST_HOLD: assert property (@(posedge i_clk) disable iff (i_rst) // RULE9
        !i_valid |=> $stable(o_dest_data) && $stable(o_destination_register))
        else $error("destination output changed without an instruction");
endmodule : ext_xor_exec

/* File: sim/tb.sv */
// Purpose: self-checking bench for the enable-write and xor execute block
// Assumes: answer one edge after a valid instruction, pulses stand one cycle
// Notes:   each op call issues one instruction and checks strobes and enable, data and flags only when written
`timescale 1ns/10ps
`include "ext_xor_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb
    import ext_xor_pkg::*;
;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_valid = 1'b0;
    logic [31:0] i_instr = 32'h0;
    logic        i_user_mode = 1'b0;
    logic [31:0] i_source_register = 32'h0;
    logic [31:0] i_second_source_register = 32'h0;
    logic        i_summary_overflow = 1'b0;
    logic        o_external_interrupt_enable, o_dest_we, o_flags_we, o_program_exception;
    logic [4:0]  o_destination_register;
    logic [31:0] o_dest_data;
    logic [3:0]  o_condition_field_zero;
    int          error_cnt = 0;
    int          n_tests = 0;

    // free-running 100 MHz clock
    always #5 i_clk = ~i_clk;

    ext_xor_exec ext_xor_exec_inst (.i_clk, .i_rst, .i_valid, .i_instr, .i_user_mode, .i_source_register,
        .i_second_source_register, .i_summary_overflow, .o_external_interrupt_enable, .o_dest_we,
        .o_destination_register, .o_dest_data, .o_flags_we, .o_condition_field_zero, .o_program_exception);

    // x-form word from its fields
    function automatic logic [31:0] enc(input logic [5:0] opc, input logic [4:0] s, input logic [4:0] d,
                                        input logic [4:0] b, input logic [9:0] xop, input logic rec);
        return {opc, s, d, b, xop, rec};
    endfunction : enc

    // issue one instruction, then check the answer one edge later
    task automatic op(input logic [31:0] ins, input logic [31:0] s, input logic [31:0] s2, input logic usr,
                      input logic so, input logic we, input logic [31:0] d, input logic cwe,
                      input logic [3:0] cr, input logic exc, input logic ee);
        @(posedge i_clk);
        i_valid <= 1'b1;
        i_instr <= ins;
        i_source_register <= s;
        i_second_source_register <= s2;
        i_user_mode <= usr;
        i_summary_overflow <= so;
        @(posedge i_clk);
        i_valid <= 1'b0;
        #1;
        `CHK("dest we", we, o_dest_we)
        if (we) begin
            `CHK("dest data", d, o_dest_data)
            `CHK("dest reg", ins[20:16], o_destination_register)
        end
        `CHK("flags we", cwe, o_flags_we)
        if (cwe) `CHK("flags", cr, o_condition_field_zero)
        `CHK("exception", exc, o_program_exception)
        `CHK("enable", ee, o_external_interrupt_enable)
        $display("test %h done", ins);
    endtask : op

    // counts, verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test

    // watchdog well beyond the few dozen cycles the tests need
    initial begin
        repeat (2000) @(posedge i_clk);
        error_cnt++;
        stop_test();
    end

    // main sequence
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        #1;
        `CHK("reset enable", `ENABLE_RESET, o_external_interrupt_enable)
        op(enc(`OPC_EXT, 5'h0, 5'h0, 5'h10, `XOP_WR_IMM, 1'b0), 32'h0, 32'h0, 0, 0, 0, 0, 0, 0, 0, 1);
        op(enc(`OPC_EXT, 5'h4, 5'h0, 5'h0, `XOP_WR_REG, 1'b0), 32'hffff_7fff, 0, 0, 0, 0, 0, 0, 0, 0, 0);
        op(enc(`OPC_EXT, 5'h4, 5'h0, 5'h0, `XOP_WR_REG, 1'b0), 32'h0000_8000, 0, 0, 0, 0, 0, 0, 0, 0, 1);
        op(enc(`OPC_EXT, 5'h0, 5'h0, 5'h0, `XOP_WR_IMM, 1'b0), 32'h0, 32'h0, 1, 0, 0, 0, 0, 0, 1, 1);
        op(enc(`OPC_EXT, 5'h4, 5'h0, 5'h0, `XOP_WR_REG, 1'b0), 32'h0, 32'h0, 1, 0, 0, 0, 0, 0, 1, 1);
        op(enc(`OPC_EXT, 5'h4, 5'h1f, 5'h1f, `XOP_WR_REG, 1'b1), 32'h0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
        op(enc(`OPC_EXT, 5'h1f, 5'h1f, 5'h1f, `XOP_WR_IMM, 1'b1), 32'h0, 0, 0, 0, 0, 0, 0, 0, 0, 1);
        op(enc(`OPC_EXT, 5'h0, 5'h0, 5'h0, `XOP_WR_IMM, 1'b0), 32'h0, 32'h0, 0, 0, 0, 0, 0, 0, 0, 0);
        op(enc(`OPC_EXT, 5'h1, 5'h9, 5'h2, `XOP_XOR, 1'b0), 32'ha5a5_0f0f, 32'hffff_0000, 1, 1,
           1, 32'h5a5a_0f0f, 0, 0, 0, 0);
        op(enc(`OPC_EXT, 5'h1, 5'h3, 5'h2, `XOP_XOR, 1'b1), 32'h8000_0000, 0, 0, 1,
           1, 32'h8000_0000, 1, 4'h9, 0, 0);
        op(enc(`OPC_EXT, 5'h1, 5'h3, 5'h2, `XOP_XOR, 1'b1), 32'h1234, 0, 0, 0, 1, 32'h1234, 1, 4'h4, 0, 0);
        op(enc(`OPC_EXT, 5'h1, 5'h3, 5'h2, `XOP_XOR, 1'b1), 32'hdead, 32'hdead, 0, 0, 1, 0, 1, 4'h2, 0, 0);
        op({`OPC_XORI, 5'h3, 5'h7, 16'h8001}, 32'hffff_ffff, 0, 0, 0, 1, 32'hffff_7ffe, 0, 0, 0, 0);
        op({`OPC_XORIS, 5'h3, 5'h7, 16'h8001}, 32'hffff_ffff, 0, 0, 0, 1, 32'h7ffe_ffff, 0, 0, 0, 0);
        stop_test();
    end
endmodule : tb
